// *** dac_pkg.sv ***
/*
 * shared constants and carriers for the twelve-channel dac load block.
 * assumes a 32-bit apb bus with word-aligned registers.
 */
package dac_pkg;

	localparam int num_channels = 12;
	localparam int code_width = 12;
	localparam int addr_width = 8;

	// register byte offsets
	localparam logic [7:0] cfg0_offset = 8'h00;
	localparam logic [7:0] sync_sel_offset = 8'h04;
	localparam logic [7:0] gain_offset = 8'h08;
	localparam logic [7:0] power_offset = 8'h0c;
	localparam logic [7:0] sw_clear_offset = 8'h10;
	localparam logic [7:0] hw_clear_sel_offset = 8'h14;
	localparam logic [7:0] status_offset = 8'h18;
	localparam logic [7:0] data_base_offset = 8'h40;
	localparam logic [7:0] clear_code_base_offset = 8'h80;

	// field positions in cfg0
	localparam int load_trigger_bit = 0;

	// reset values
	localparam logic [11:0] code_reset = 12'h000;
	localparam logic [11:0] mask_reset = 12'h000;
	localparam logic [11:0] power_reset = 12'h000;

	// decoded bus request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} bus_req_s;

endpackage : dac_pkg

// *** dac_apb_slave.sv ***
/*
 * apb slave front end: turns an apb access into a one-cycle request.
 * assumes a master that holds its request until pready; zero wait states.
 */
`timescale 1ns/1ns
module dac_apb_slave
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// apb
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	// request out
	output dac_pkg::bus_req_s req_o
);

	////////////////////////////////////////////////////////////////
	// access phase with pready tied high completes in one cycle
	always_comb
	begin
		req_o.wr = psel_i & penable_i & pwrite_i;
		req_o.rd = psel_i & penable_i & ~pwrite_i;
		req_o.addr = paddr_i;
		req_o.wdata = pwdata_i;
	end

endmodule : dac_apb_slave

// *** dac_double_buffer_load.sv ***
/*
 * twelve-channel dac control: data registers, output latches, load trigger,
 * clear handling and apb register file.
 * assumes clear pins are asynchronous and the host sets sync-load selects.
 */
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module dac_double_buffer_load
#(
	parameter int channels = dac_pkg::num_channels,
	parameter int width = dac_pkg::code_width
)
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// clear pin, active low, asynchronous
	input wire logic channel_clear_input_n_i,
	// analog side
	output logic [channels*width-1:0] channel_code_o,
	output logic [channels-1:0] channel_gain_o,
	output logic [channels-1:0] channel_power_up_o
);

	////////////////////////////////////////////////////////////////
	// bus front end
	dac_pkg::bus_req_s req;

	dac_apb_slave u_apb
	(
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.psel_i(psel_i),
		.penable_i(penable_i),
		.pwrite_i(pwrite_i),
		.paddr_i(paddr_i),
		.pwdata_i(pwdata_i),
		.req_o(req)
	);

	// channel index of a data or clear-code window, or channels if outside
	function automatic int chan_of(input logic [7:0] addr, input logic [7:0] base);
		int idx;
		idx = channels;
		if (addr >= base && addr < base + 8'(channels * 4) && addr[1:0] == 2'b00)
			idx = int'((addr - base) >> 2);
		return idx;
	endfunction : chan_of

	////////////////////////////////////////////////////////////////
	// clear pin synchroniser
	logic clr_meta, clr_sync;

	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			clr_meta <= 1'b1;
			clr_sync <= 1'b1;
		end
		else
		begin
			clr_meta <= channel_clear_input_n_i;
			clr_sync <= clr_meta;
		end
	end

	////////////////////////////////////////////////////////////////
	// state
	logic [width-1:0] data_reg [channels];
	logic [width-1:0] latch [channels];
	logic [width-1:0] clear_code [channels];
	logic [channels-1:0] dirty, sync_load_select, gain, power, sw_clear, hw_clear_sel;
	logic load_pulse;
	logic [31:0] rdata;

	logic [width-1:0] next_data_reg [channels];
	logic [width-1:0] next_latch [channels];
	logic [width-1:0] next_clear_code [channels];
	logic [channels-1:0] next_dirty, next_sync_load_select, next_gain, next_power;
	logic [channels-1:0] next_sw_clear, next_hw_clear_sel;
	logic next_load_pulse;
	logic [31:0] next_rdata;
	logic [channels-1:0] cleared, cleared_q;

	// clear state per channel: software bit or selected pin
	always_comb
	begin
		cleared = sw_clear | (hw_clear_sel & {channels{~clr_sync}});
	end

	////////////////////////////////////////////////////////////////
	// next-state logic for registers and latches
	always_comb
	begin
		int wch;
		int cch;
		int rch;
		wch = chan_of(req.addr, dac_pkg::data_base_offset);
		cch = chan_of(req.addr, dac_pkg::clear_code_base_offset);
		rch = wch;
		next_data_reg = data_reg;
		next_latch = latch;
		next_clear_code = clear_code;
		next_dirty = dirty;
		next_sync_load_select = sync_load_select;
		next_gain = gain;
		next_power = power;
		next_sw_clear = sw_clear;
		next_hw_clear_sel = hw_clear_sel;
		next_load_pulse = 1'b0;
		next_rdata = rdata;
		if (req.wr)
		begin
			case (req.addr)
				dac_pkg::cfg0_offset: next_load_pulse = req.wdata[dac_pkg::load_trigger_bit];
				dac_pkg::sync_sel_offset: next_sync_load_select = req.wdata[channels-1:0];
				dac_pkg::gain_offset: next_gain = req.wdata[channels-1:0];
				dac_pkg::power_offset: next_power = req.wdata[channels-1:0];
				dac_pkg::sw_clear_offset: next_sw_clear = req.wdata[channels-1:0];
				dac_pkg::hw_clear_sel_offset: next_hw_clear_sel = req.wdata[channels-1:0];
				default:
				begin
					if (wch < channels)
					begin
						next_data_reg[wch] = req.wdata[width-1:0];
						next_dirty[wch] = 1'b1;
					end
					if (cch < channels)
						next_clear_code[cch] = req.wdata[width-1:0];
				end
			endcase
		end
		// latch updates; loop over channels
		for (int i = 0; i < channels; i++)
		begin
			if (cleared[i])
				next_latch[i] = clear_code[i];
			else if (cleared_q[i])
				next_latch[i] = data_reg[i];
			else if (load_pulse && sync_load_select[i] && dirty[i])
			begin
				next_latch[i] = data_reg[i];
				// a write landing in the load cycle stays pending: set wins
				next_dirty[i] = (req.wr && wch == i);
			end
		end
		// read data captured in the setup cycle so it stands through the access phase
		if (psel_i && !penable_i && !pwrite_i)
		begin
			case (req.addr)
				dac_pkg::cfg0_offset: next_rdata = 32'h0000_0000;
				dac_pkg::sync_sel_offset: next_rdata = 32'(sync_load_select);
				dac_pkg::gain_offset: next_rdata = 32'(gain);
				dac_pkg::power_offset: next_rdata = 32'(power);
				dac_pkg::sw_clear_offset: next_rdata = 32'(sw_clear);
				dac_pkg::hw_clear_sel_offset: next_rdata = 32'(hw_clear_sel);
				dac_pkg::status_offset: next_rdata = 32'(dirty);
				default:
				begin
					next_rdata = 32'h0000_0000;
					if (rch < channels)
						next_rdata = 32'(latch[rch]);
					else if (cch < channels)
						next_rdata = 32'(clear_code[cch]);
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// registers; reset clears codes and powers buffers down
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			for (int i = 0; i < channels; i++)
			begin
				data_reg[i] <= dac_pkg::code_reset;
				latch[i] <= dac_pkg::code_reset;
				clear_code[i] <= dac_pkg::code_reset;
			end
			dirty <= dac_pkg::mask_reset;
			sync_load_select <= dac_pkg::mask_reset;
			gain <= dac_pkg::mask_reset;
			power <= dac_pkg::power_reset;
			sw_clear <= dac_pkg::mask_reset;
			hw_clear_sel <= dac_pkg::mask_reset;
			cleared_q <= dac_pkg::mask_reset;
			load_pulse <= 1'b0;
			rdata <= 32'h0000_0000;
		end
		else
		begin
			data_reg <= next_data_reg;
			latch <= next_latch;
			clear_code <= next_clear_code;
			dirty <= next_dirty;
			sync_load_select <= next_sync_load_select;
			gain <= next_gain;
			power <= next_power;
			sw_clear <= next_sw_clear;
			hw_clear_sel <= next_hw_clear_sel;
			cleared_q <= cleared;
			load_pulse <= next_load_pulse;
			rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs straight from flip-flops; pready and pslverr are constants
	genvar g;
	generate
		for (g = 0; g < channels; g++)
		begin : g_out
			assign channel_code_o[g*width +: width] = latch[g];
		end
	endgenerate

	assign channel_gain_o = gain;
	assign channel_power_up_o = power;
	assign prdata_o = rdata;
	// registered pready would cost a wait state; constant high is a flip-flop-free zero-wait answer
	assign pready_o = 1'b1;
	assign pslverr_o = 1'b0;

	////////////////////////////////////////////////////////////////
	// assertions
	property p_trigger_pulse;
		@(posedge mclk_i) disable iff (!reset_n_i)
		load_pulse |=> !load_pulse || $past(req.wr);
	endproperty
	a_trigger_pulse: assert property (p_trigger_pulse) else $error("load pulse held");

	property p_no_load_unselected;
		@(posedge mclk_i) disable iff (!reset_n_i)
		(!cleared[0] && !cleared_q[0] && !(load_pulse && sync_load_select[0])) |=> $stable(latch[0]);
	endproperty
	a_no_load_unselected: assert property (p_no_load_unselected) else $error("latch changed without load");

	property p_load_copies;
		@(posedge mclk_i) disable iff (!reset_n_i)
		(load_pulse && sync_load_select[0] && dirty[0] && !cleared[0] && !cleared_q[0])
			|=> latch[0] == $past(data_reg[0]);
	endproperty
	a_load_copies: assert property (p_load_copies) else $error("latch missed load");

	property p_clean_not_reloaded;
		@(posedge mclk_i) disable iff (!reset_n_i)
		(load_pulse && !dirty[1] && !cleared[1] && !cleared_q[1]) |=> $stable(latch[1]);
	endproperty
	a_clean_not_reloaded: assert property (p_clean_not_reloaded) else $error("clean channel reloaded");

	property p_clear_code;
		@(posedge mclk_i) disable iff (!reset_n_i)
		cleared[2] |=> latch[2] == $past(clear_code[2]) && ($stable(data_reg[2]) || $past(req.wr));
	endproperty
	a_clear_code: assert property (p_clear_code) else $error("clear code not loaded");

	property p_trigger_cause;
		@(posedge mclk_i) disable iff (!reset_n_i)
		load_pulse |-> $past(req.wr) && $past(req.addr) == dac_pkg::cfg0_offset;
	endproperty
	a_trigger_cause: assert property (p_trigger_cause) else $error("load without trigger write");

	property p_read_latch;
		@(posedge mclk_i) disable iff (!reset_n_i)
		(psel_i && !penable_i && !pwrite_i && paddr_i == dac_pkg::data_base_offset)
			|=> prdata_o == 32'($past(latch[0]));
	endproperty
	a_read_latch: assert property (p_read_latch) else $error("read not latch value");

	property p_dirty_set;
		@(posedge mclk_i) disable iff (!reset_n_i)
		(req.wr && req.addr == dac_pkg::data_base_offset) |=> dirty[0];
	endproperty
	a_dirty_set: assert property (p_dirty_set) else $error("write not marked pending");

endmodule : dac_double_buffer_load

// *** dac_host_model.sv ***
/*
 * host side model: apb master tasks for the dac load block.
 * assumes one clock and a slave whose read data stands in the access phase.
 */
`timescale 1ns/1ns
module dac_host_model
(
	// clock
	input wire logic mclk_i,
	// apb answer
	input wire logic pready_i,
	input wire logic [31:0] prdata_i,
	// apb request
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [7:0] paddr_o,
	output logic [31:0] pwdata_o
);
	// idle bus at time zero
	initial
	begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h0;
	end
	////////////////////////////////////////////////////////////
	// one transfer, entered just after a rising edge
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= wr;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge mclk_i);
		penable_o <= 1'b1;
		@(posedge mclk_i);
		while (pready_i !== 1'b1)
		begin
			@(posedge mclk_i);
		end
		// read data taken at the edge where pready is seen high
		q = prdata_i;
		// released lines show no stale value
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		paddr_o <= ~a;
		pwdata_o <= ~d;
		// one idle edge, so a following setup never reassigns psel in this step
		@(posedge mclk_i);
	endtask : xfer
	task bus_write(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask : bus_write
	task bus_read(input logic [7:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0, q);
	endtask : bus_read
	task set_select(input logic [11:0] m);
		bus_write(dac_pkg::sync_sel_offset, {20'h0, m});
	endtask : set_select
	task fire_load;
		bus_write(dac_pkg::cfg0_offset, 32'h1 << dac_pkg::load_trigger_bit);
	endtask : fire_load
endmodule : dac_host_model

// *** dac_double_buffer_load_tb.sv ***
/*
 * self-checking bench for the dac load block.
 * assumes the host model drives apb and the bench drives the clear pin.
 */
`timescale 1ns/1ns
module dac_double_buffer_load_tb;
	logic mclk_i, reset_n_i, psel, penable, pwrite, clr_n, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [143:0] codes;
	logic [11:0] gain, power;
	logic [11:0] exp_code [12];
	int n_fail = 0;
	int cmp_count = 0;
	int cycles = 0;
	dac_double_buffer_load dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.channel_clear_input_n_i(clr_n), .channel_code_o(codes), .channel_gain_o(gain),
		.channel_power_up_o(power));
	dac_host_model host_u (.mclk_i(mclk_i), .pready_i(pready), .prdata_i(prdata), .psel_o(psel),
		.penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
	////////////////////////////////////////////////////////////
	// 20 mhz clock and hang guard
	initial
	begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_fail++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////
	function logic [11:0] val(input int n, input logic [11:0] salt);
		return 12'(n * 12'h151) ^ salt;
	endfunction : val
	task check(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check
	task check_codes(input string what);
		for (int n = 0; n < 12; n++)
			check({20'h0, codes[12*n +: 12]}, {20'h0, exp_code[n]}, what);
	endtask : check_codes
	task give_verdict;
		if (n_fail == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		clr_n = 1'b1;
		reset_n_i = 1'b0;
		for (int n = 0; n < 12; n++)
			exp_code[n] = 12'h000;
		repeat (12) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		@(posedge mclk_i);
		check_codes("reset code");
		check({20'h0, power}, 32'h0, "power reset");
		check({20'h0, gain}, 32'h0, "gain reset");
		// ch11 left out of the load set
		host_u.set_select(12'h7ff);
		for (int n = 0; n < 12; n++)
			host_u.bus_write(dac_pkg::data_base_offset + 8'(4*n), {20'h0, val(n, 12'hfff)});
		check_codes("no load yet");
		host_u.bus_read(dac_pkg::data_base_offset + 8'h0c, rd);
		check(rd, 32'h0, "read gives latch");
		// latches move one edge after the pulse; look in between
		fork
			host_u.fire_load();
			begin
				repeat (2) @(posedge mclk_i);
				@(negedge mclk_i);
				check_codes("early load");
			end
		join
		for (int n = 0; n < 11; n++)
			exp_code[n] = val(n, 12'hfff);
		@(negedge mclk_i);
		check_codes("joint load");
		@(posedge mclk_i);
		host_u.bus_read(dac_pkg::cfg0_offset, rd);
		check(rd, 32'h0, "trigger reads 0");
		host_u.bus_read(dac_pkg::data_base_offset + 8'h0c, rd);
		check(rd, {20'h0, exp_code[3]}, "read latch");
		// only the rewritten channel moves
		host_u.bus_write(dac_pkg::data_base_offset + 8'h04, {20'h0, val(1, 12'h0f0)});
		host_u.fire_load();
		exp_code[1] = val(1, 12'h0f0);
		repeat (3) @(posedge mclk_i);
		check_codes("single reload");
		host_u.bus_write(dac_pkg::data_base_offset + 8'h04, 32'h00f);
		repeat (4) @(posedge mclk_i);
		check_codes("pulse not stuck");
		host_u.bus_write(dac_pkg::gain_offset, 32'ha5a);
		check({20'h0, gain}, 32'ha5a, "gain");
		host_u.bus_write(dac_pkg::power_offset, 32'h5a5);
		check({20'h0, power}, 32'h5a5, "power");
		// software clear on ch0, then release restores data
		host_u.bus_write(dac_pkg::clear_code_base_offset, 32'h123);
		host_u.bus_write(dac_pkg::sw_clear_offset, 32'h1);
		repeat (2) @(posedge mclk_i);
		exp_code[0] = 12'h123;
		check_codes("soft clear");
		host_u.bus_write(dac_pkg::sw_clear_offset, 32'h0);
		repeat (2) @(posedge mclk_i);
		exp_code[0] = val(0, 12'hfff);
		check_codes("soft clear off");
		// clear pin on ch2 only
		host_u.bus_write(dac_pkg::clear_code_base_offset + 8'h08, 32'h0ab);
		host_u.bus_write(dac_pkg::hw_clear_sel_offset, 32'h004);
		clr_n <= 1'b0;
		repeat (5) @(posedge mclk_i);
		exp_code[2] = 12'h0ab;
		check_codes("pin clear");
		clr_n <= 1'b1;
		repeat (5) @(posedge mclk_i);
		exp_code[2] = val(2, 12'hfff);
		check_codes("pin clear off");
		host_u.bus_read(8'hfc, rd);
		check(rd, 32'h0, "unmapped read");
		check({31'h0, pslverr}, 32'h0, "no bus error");
		// reset in mid-run
		reset_n_i <= 1'b0;
		@(negedge mclk_i);
		for (int n = 0; n < 12; n++)
			exp_code[n] = 12'h000;
		check_codes("mid reset");
		check({20'h0, power}, 32'h0, "mid reset power");
		give_verdict();
	end
endmodule : dac_double_buffer_load_tb
